// [dv/ohcib_rom_node.sv]
// remote serial-bus node that fetches config rom quadlets
// assumes the rom port of ohcib_regs on the same clock; used by the bench
`timescale 1ns/1ps
module ohcib_rom_node (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] rom_data_i,
  input  wire logic        rom_valid_i,
  output logic             rom_rd_o,
  output logic      [1:0]  rom_quad_o
);
  initial begin
    rom_rd_o   = 1'h0;
    rom_quad_o = 2'h3;
  end

  // ----------------------------------------------------------------
  // one quadlet read
  // ----------------------------------------------------------------
  // the quadlet lines carry the inverse of the last requested index between requests
  task automatic fetch(input logic [1:0] q, output logic [31:0] d, output logic ok);
    ok = 1'b0;
    d  = 32'h0;
    @(posedge clk_i);
    rom_rd_o   <= 1'h1;
    rom_quad_o <= q;
    @(posedge clk_i);
    rom_rd_o   <= 1'h0;
    rom_quad_o <= ~q;
    repeat (8) begin
      @(posedge clk_i);
      if (!ok && rom_valid_i === 1'b1) begin
        d  = rom_data_i;
        ok = 1'b1;
      end
    end
  endtask : fetch
endmodule : ohcib_rom_node

// [dv/tb_ohci_csr_bus_info_regs.sv]
// self-checking bench for the bus-info register group
// assumes ohcib_regs with a classic wishbone slave and a rom port node
`timescale 1ns/1ps
module tb_ohci_csr_bus_info_regs;
  import ohcib_pkg::*;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rom_data_o, rd;
  logic        rom_rd_i, rom_valid_o, link_active_enable_o, irq_o, ok;
  logic [1:0]  rom_quad_i;
  int          mismatches, compares;

  ohcib_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rom_rd_i(rom_rd_i),
    .rom_quad_i(rom_quad_i), .rom_data_o(rom_data_o), .rom_valid_o(rom_valid_o),
    .link_active_enable_o(link_active_enable_o), .irq_o(irq_o));
  ohcib_rom_node node_u (.clk_i(clk_i), .rst_i(rst_i), .rom_data_i(rom_data_o),
    .rom_valid_i(rom_valid_o), .rom_rd_o(rom_rd_i), .rom_quad_o(rom_quad_i));

  // ----------------------------------------------------------------
  // clock, reset and helpers
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  // one classic cycle; the request holds until ack is sampled high
  task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [31:0] q);
    q = 32'h0;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    // no local limit: only the watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i  <= 1'h0;
  endtask : wb_cycle

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    wb_cycle(1'b1, a, d, s, q);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_cycle(1'b0, a, 32'h0, 4'hf, q);
    check(q, exp);
  endtask : rd_chk

  task automatic hw_reset();
    rst_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
  endtask : hw_reset

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    rd_chk(OFF_CSWAP_CTRL, 32'h80000000);
    rd_chk(OFF_ROM_HDR,    32'h00000000);
    rd_chk(OFF_BUS_ID,     32'h31333934);
    rd_chk(OFF_BUS_OPT,    32'h0000a002);
    rd_chk(8'h3c,          32'h00000000);
    $display("test reset values done");
  endtask : t_reset_values

  task automatic t_access();
    wr(OFF_ROM_HDR, 32'h04a5c3e1, 4'hf);
    rd_chk(OFF_ROM_HDR, 32'h04a5c3e1);
    wr(OFF_BUS_ID, 32'h0, 4'hf);
    rd_chk(OFF_BUS_ID, 32'h31333934);
    wr(OFF_BUS_OPT, 32'hffffffff, 4'h8);
    rd_chk(OFF_BUS_OPT, 32'hc000a002);
    wr(OFF_BUS_OPT, 32'h0000ffff, 4'h1);
    rd_chk(OFF_BUS_OPT, 32'hc000a002);
    node_u.fetch(ROMQ_HEADER, rd, ok);
    check({31'h0, ok}, 32'h1);
    check(rd, 32'h04a5c3e1);
    node_u.fetch(ROMQ_BUS_ID, rd, ok);
    check({31'h0, ok}, 32'h1);
    check(rd, 32'h31333934);
    node_u.fetch(ROMQ_BUS_OPT, rd, ok);
    check({31'h0, ok}, 32'h1);
    check(rd, 32'hc000a002);
    // the unused quadlet index reads as zero
    node_u.fetch(2'h3, rd, ok);
    check({31'h0, ok}, 32'h1);
    check(rd, 32'h00000000);
    $display("test access done");
  endtask : t_access

  task automatic t_done_flag();
    wr(OFF_CSWAP_CTRL, 32'hffffffff, 4'hf);
    rd_chk(OFF_CSWAP_CTRL, 32'h00000003);
    repeat (6) @(posedge clk_i);
    rd_chk(OFF_CSWAP_CTRL, 32'h80000003);
    wr(OFF_INT_STAT, 32'h3, 4'h1);
    $display("test done flag done");
  endtask : t_done_flag

  // a swap on one resource; status bit1 tells a compare miss
  task automatic cswap(input logic [1:0] s, input logic [31:0] cmp, input logic [31:0] d,
                       input logic miss);
    wr(OFF_CSR_DATA, d, 4'hf);
    wr(OFF_CSR_CMP, cmp, 4'hf);
    wr(OFF_CSWAP_CTRL, {30'h0, s}, 4'hf);
    repeat (6) @(posedge clk_i);
    rd_chk(OFF_CSWAP_CTRL, {1'b1, 29'h0, s});
    rd_chk(OFF_INT_STAT, {30'h0, miss, 1'b1});
    wr(OFF_INT_STAT, 32'h3, 4'h1);
  endtask : cswap

  task automatic t_swap_all();
    for (int s = 0; s < 4; s++) begin
      cswap(s[1:0], 32'h0, 32'h00a0 + s, 1'b0);
      cswap(s[1:0], 32'h00a0 + s, 32'h0, 1'b0);
      cswap(s[1:0], 32'h00a0 + s, 32'h5, 1'b1);
    end
    $display("test swap all done");
  endtask : t_swap_all

  task automatic t_irq();
    wr(OFF_INT_MASK, 32'h2, 4'h1);
    wr(OFF_CSR_CMP, 32'h77, 4'hf);
    wr(OFF_CSWAP_CTRL, 32'h0, 4'hf);
    repeat (6) @(posedge clk_i);
    check({31'h0, irq_o}, 32'h1);
    // the mask lands on the ack edge, so irq is looked at one edge later
    wr(OFF_INT_MASK, 32'h0, 4'h1);
    @(posedge clk_i);
    check({31'h0, irq_o}, 32'h0);
    wr(OFF_INT_MASK, 32'h3, 4'h1);
    @(posedge clk_i);
    check({31'h0, irq_o}, 32'h1);
    wr(OFF_INT_STAT, 32'h3, 4'h1);
    @(posedge clk_i);
    check({31'h0, irq_o}, 32'h0);
    $display("test irq done");
  endtask : t_irq

  task automatic t_soft_reset();
    wr(OFF_BUS_OPT, 32'h00005000, 4'h2);
    wr(OFF_HC_CTRL, 32'h00020000, 4'h4);
    @(posedge clk_i);
    check({31'h0, link_active_enable_o}, 32'h1);
    // link bit written high too, so only the software reset can drop it
    wr(OFF_HC_CTRL, 32'h00030000, 4'h4);
    @(posedge clk_i);
    check({31'h0, link_active_enable_o}, 32'h0);
    rd_chk(OFF_ROM_HDR, 32'h0);
    rd_chk(OFF_BUS_OPT, 32'h00005002);
    hw_reset();
    rd_chk(OFF_BUS_OPT, 32'h0000a002);
    $display("test soft reset done");
  endtask : t_soft_reset

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    mismatches = 0;
    compares   = 0;
    rst_i      = 1'h1;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i   = 8'h0;
    wb_sel_i   = 4'h0;
    wb_dat_i   = 32'h0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset_values();
    t_access();
    t_done_flag();
    t_swap_all();
    t_irq();
    t_soft_reset();
    close_out();
  end

  // the tests need about four hundred cycles
  initial begin
    #(25 * 20000);
    mismatches++;
    close_out();
  end
endmodule : tb_ohci_csr_bus_info_regs

// [include/ohcib_pkg.sv]
// package of constants for the bus-info register group
// assumes a 32-bit classic wishbone slave with byte addresses on 8 bits
package ohcib_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CSR_DATA   = 8'h0c;
  localparam logic [7:0] OFF_CSR_CMP    = 8'h10;
  localparam logic [7:0] OFF_CSWAP_CTRL = 8'h14;
  localparam logic [7:0] OFF_ROM_HDR    = 8'h18;
  localparam logic [7:0] OFF_BUS_ID     = 8'h1c;
  localparam logic [7:0] OFF_BUS_OPT    = 8'h20;
  localparam logic [7:0] OFF_INT_STAT   = 8'h40;
  localparam logic [7:0] OFF_INT_MASK   = 8'h44;
  localparam logic [7:0] OFF_HC_CTRL    = 8'h50;

  // ----------------------------------------------------------------
  // field positions and fixed values
  // ----------------------------------------------------------------
  localparam int          DONE_BIT      = 31;
  localparam int          IRMC_BIT      = 31;
  localparam int          CMC_BIT       = 30;
  localparam int          LINK_EN_BIT   = 17;
  localparam int          SOFT_RST_BIT  = 16;
  localparam int          EVT_DONE      = 0;
  localparam int          EVT_MISS      = 1;
  localparam int          NUM_EVT       = 2;
  localparam logic [31:0] BUS_ID_VALUE  = 32'h31333934;
  localparam logic [2:0]  LINK_SPEED    = 3'h2;
  localparam logic [3:0]  MAX_REC_RST   = 4'ha;
  localparam logic        DONE_RST      = 1'h1;
  localparam logic [31:0] HDR_RST       = 32'h00000000;

  // config rom quadlet index seen by remote nodes
  localparam logic [1:0]  ROMQ_HEADER   = 2'h0;
  localparam logic [1:0]  ROMQ_BUS_ID   = 2'h1;
  localparam logic [1:0]  ROMQ_BUS_OPT  = 2'h2;

  // compare-swap engine states, one-hot
  typedef enum logic [2:0] {
    CS_IDLE = 3'b001,
    CS_READ = 3'b010,
    CS_CMP  = 3'b100
  } ohcib_cs_state_t;

endpackage : ohcib_pkg

// [rtl/ohcib_evt_bank.sv]
// sticky event bits, write-one-to-clear, with a mask onto one irq level
// assumes set and clear strobes are synchronous one-cycle pulses
`timescale 1ns/1ps
module ohcib_evt_bank
  import ohcib_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic [NUM_EVT-1:0] set_i,
  input  wire logic [NUM_EVT-1:0] clr_i,
  input  wire logic               mask_we_i,
  input  wire logic [NUM_EVT-1:0] mask_i,
  output logic      [NUM_EVT-1:0] status_o,
  output logic      [NUM_EVT-1:0] mask_o,
  output logic                    irq_o
);

  logic [NUM_EVT-1:0] stat_next;

  // set beats clear so an event in the clearing cycle survives
  for (genvar g = 0; g < NUM_EVT; g++) begin : g_bit
    always_comb begin
      stat_next[g] = set_i[g] | (status_o[g] & ~clr_i[g]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_o <= '0;
      mask_o   <= '0;
    end else begin
      status_o <= stat_next;
      mask_o   <= mask_we_i ? mask_i : mask_o;
    end
  end

  assign irq_o = |(status_o & mask_o);

endmodule : ohcib_evt_bank

// [rtl/ohcib_regs.sv]
// bus-info register group with compare-swap engine and rom quadlet port
// assumes a classic wishbone master and a remote-read requester on clk_i
//
// Functional notes
// - a finished compare-swap sets the completion flag, bit 31 of control.
// - a write to the compare-swap control register clears that flag, unless a swap completes in that cycle.
// - bits 1-0 pick the resource: manager id, bandwidth, channels hi, lo.
// - control bits 30-2 always read as zero.
// - the rom header is the first rom quadlet seen by the serial bus.
// - header holds info length, crc length and crc value; lengths reset 0.
// - bus identification is read-only and always returns 31333934h.
// - bus options is the second bus info quadlet seen by the serial bus.
// - bus options bits 31 and 30 are writable capability bits, reset 0.
// - bus options bits 2-0 are read-only and return 010b.
// - max request bits 15-12 reset to ah and survive a software reset.
`timescale 1ns/1ps
module ohcib_regs
  import ohcib_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rom_rd_i,
  input  wire logic [1:0]  rom_quad_i,
  output logic      [31:0] rom_data_o,
  output logic             rom_valid_o,
  output logic             link_active_enable_o,
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] bmerge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : bmerge

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic                 ack_reg,   ack_next;
  logic [31:0]          dat_reg,   dat_next;
  logic [1:0]           sel_reg,   sel_next;
  logic                 done_reg,  done_next;
  logic [31:0]          data_reg,  data_next;
  logic [31:0]          cmp_reg,   cmp_next;
  logic [31:0]          hdr_reg,   hdr_next;
  logic                 irmc_reg,  irmc_next;
  logic                 cmc_reg,   cmc_next;
  logic [3:0]           mrec_reg,  mrec_next;
  logic                 link_reg,  link_next;
  logic [31:0]          romd_reg,  romd_next;
  logic                 romv_reg,  romv_next;
  ohcib_cs_state_t      state_reg, state_next;
  logic                 wr_fire;
  logic                 soft_rst;
  logic                 start;
  logic                 mem_we;
  logic [31:0]          mem_rdata;
  logic [31:0]          opt_word;
  logic [31:0]          ctrl_word;
  logic [NUM_EVT-1:0]   evt_set;
  logic [NUM_EVT-1:0]   evt_clr;
  logic [NUM_EVT-1:0]   evt_stat;
  logic [NUM_EVT-1:0]   evt_mask;

  // a write lands only on the edge where the master sees ack high
  assign wr_fire  = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
  assign soft_rst = wr_fire & (wb_adr_i == OFF_HC_CTRL) & wb_sel_i[2]
                    & wb_dat_i[SOFT_RST_BIT];
  assign start    = wr_fire & (wb_adr_i == OFF_CSWAP_CTRL)
                    & (state_reg == CS_IDLE);

  // read views of the mixed registers
  assign ctrl_word = {done_reg, 29'h00000000, sel_reg};
  assign opt_word  = {irmc_reg, cmc_reg, 14'h0000, mrec_reg,
                      9'h000, LINK_SPEED};

  // ----------------------------------------------------------------
  // wishbone slave: ack one cycle after request, read data registered
  // ----------------------------------------------------------------
  always_comb begin
    ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
    dat_next = dat_reg;
    if (wb_cyc_i & wb_stb_i & ~ack_reg) begin
      case (wb_adr_i)
        OFF_CSR_DATA:   dat_next = data_reg;
        OFF_CSR_CMP:    dat_next = cmp_reg;
        OFF_CSWAP_CTRL: dat_next = ctrl_word;
        OFF_ROM_HDR:    dat_next = hdr_reg;
        OFF_BUS_ID:     dat_next = BUS_ID_VALUE;
        OFF_BUS_OPT:    dat_next = opt_word;
        OFF_INT_STAT:   dat_next = {30'h00000000, evt_stat};
        OFF_INT_MASK:   dat_next = {30'h00000000, evt_mask};
        OFF_HC_CTRL:    dat_next = {14'h0000, link_reg, 17'h00000};
        default:        dat_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // soft reset clears the rom header, bus options bits 31-30 and the link bit; max request is kept
  always_comb begin
    sel_next  = sel_reg;
    done_next = done_reg;
    data_next = data_reg;
    cmp_next  = cmp_reg;
    hdr_next  = hdr_reg;
    irmc_next = irmc_reg;
    cmc_next  = cmc_reg;
    mrec_next = mrec_reg;
    link_next = link_reg;
    if (wr_fire) begin
      case (wb_adr_i)
        OFF_CSR_DATA: data_next = bmerge(data_reg, wb_dat_i, wb_sel_i);
        OFF_CSR_CMP:  cmp_next  = bmerge(cmp_reg, wb_dat_i, wb_sel_i);
        OFF_CSWAP_CTRL: begin
          done_next = 1'b0;
          if (wb_sel_i[0] & (state_reg == CS_IDLE)) begin
            sel_next = wb_dat_i[1:0];
          end
        end
        OFF_ROM_HDR:  hdr_next  = bmerge(hdr_reg, wb_dat_i, wb_sel_i);
        OFF_BUS_OPT: begin
          if (wb_sel_i[3]) begin
            irmc_next = wb_dat_i[IRMC_BIT];
            cmc_next  = wb_dat_i[CMC_BIT];
          end
          if (wb_sel_i[1]) begin
            mrec_next = wb_dat_i[15:12];
          end
        end
        OFF_HC_CTRL: begin
          if (wb_sel_i[2]) begin
            link_next = wb_dat_i[LINK_EN_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    if (soft_rst) begin
      hdr_next  = HDR_RST;
      irmc_next = 1'b0;
      cmc_next  = 1'b0;
      link_next = 1'b0;
    end
    // completion wins over a clearing write in the same cycle
    if (state_reg == CS_CMP) begin
      done_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_reg  <= 2'h0;
      done_reg <= DONE_RST;
      data_reg <= 32'h00000000;
      cmp_reg  <= 32'h00000000;
      hdr_reg  <= HDR_RST;
      irmc_reg <= 1'b0;
      cmc_reg  <= 1'b0;
      mrec_reg <= MAX_REC_RST;
      link_reg <= 1'b0;
    end else begin
      sel_reg  <= sel_next;
      done_reg <= done_next;
      data_reg <= data_next;
      cmp_reg  <= cmp_next;
      hdr_reg  <= hdr_next;
      irmc_reg <= irmc_next;
      cmc_reg  <= cmc_next;
      mrec_reg <= mrec_next;
      link_reg <= link_next;
    end
  end

  // the link only reads fields software promised to hold steady
  assign link_active_enable_o = link_reg;

  // ----------------------------------------------------------------
  // compare-swap engine
  // ----------------------------------------------------------------
  // read costs one cycle since the store's data is registered
  always_comb begin
    state_next = state_reg;
    mem_we     = 1'b0;
    evt_set    = '0;
    case (state_reg)
      CS_IDLE: begin
        if (start) begin
          state_next = CS_READ;
        end
      end
      CS_READ: state_next = CS_CMP;
      CS_CMP: begin
        mem_we              = (mem_rdata == cmp_reg);
        evt_set[EVT_DONE]   = 1'b1;
        evt_set[EVT_MISS]   = (mem_rdata != cmp_reg);
        state_next          = CS_IDLE;
      end
      default: state_next = CS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= CS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  ohcib_res_mem u_mem (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .we_i    (mem_we),
    .waddr_i (sel_reg),
    .wdata_i (data_reg),
    .raddr_i (sel_reg),
    .rdata_o (mem_rdata)
  );

  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  assign evt_clr = (wr_fire & (wb_adr_i == OFF_INT_STAT) & wb_sel_i[0])
                   ? wb_dat_i[NUM_EVT-1:0] : '0;

  ohcib_evt_bank u_evt (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .set_i     (evt_set),
    .clr_i     (evt_clr),
    .mask_we_i (wr_fire & (wb_adr_i == OFF_INT_MASK) & wb_sel_i[0]),
    .mask_i    (wb_dat_i[NUM_EVT-1:0]),
    .status_o  (evt_stat),
    .mask_o    (evt_mask),
    .irq_o     (irq_o)
  );

  // ----------------------------------------------------------------
  // serial bus view of the rom quadlets
  // ----------------------------------------------------------------
  always_comb begin
    romv_next = rom_rd_i;
    romd_next = romd_reg;
    if (rom_rd_i) begin
      case (rom_quad_i)
        ROMQ_HEADER:  romd_next = hdr_reg;
        ROMQ_BUS_ID:  romd_next = BUS_ID_VALUE;
        ROMQ_BUS_OPT: romd_next = opt_word;
        default:      romd_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      romd_reg <= 32'h00000000;
      romv_reg <= 1'b0;
    end else begin
      romd_reg <= romd_next;
      romv_reg <= romv_next;
    end
  end

  assign rom_data_o  = romd_reg;
  assign rom_valid_o = romv_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_swap_run;
    state_reg == CS_READ ##1 state_reg == CS_CMP ##1 done_reg;
  endsequence

  a_swap_done_seq: assert property (start |=> s_swap_run)
    else $error("swap did not finish with done set in two cycles");
  a_done_clears: assert property (
    wr_fire && wb_adr_i == OFF_CSWAP_CTRL && state_reg != CS_CMP |=> !done_reg)
    else $error("control write did not clear done");
  a_sel_taken: assert property (
    start && wb_sel_i[0] |=> sel_reg == $past(wb_dat_i[1:0]))
    else $error("resource select not stored");
  a_ctrl_rsvd_zero: assert property (
    ack_reg && $past(wb_adr_i) == OFF_CSWAP_CTRL |-> wb_dat_o[30:2] == 0)
    else $error("control reserved bits not zero");
  a_rom_header_view: assert property (
    rom_rd_i && rom_quad_i == ROMQ_HEADER
    |=> rom_valid_o && rom_data_o == $past(hdr_reg))
    else $error("rom header quadlet wrong");
  a_bus_id_const: assert property (
    ack_reg && $past(wb_adr_i) == OFF_BUS_ID |-> wb_dat_o == BUS_ID_VALUE)
    else $error("bus id value wrong");
  a_rom_opt_view: assert property (
    rom_rd_i && rom_quad_i == ROMQ_BUS_OPT
    |=> rom_data_o[2:0] == 3'h2 && rom_data_o[15:12] == $past(mrec_reg))
    else $error("rom bus options quadlet wrong");
  a_speed_fixed: assert property (
    ack_reg && $past(wb_adr_i) == OFF_BUS_OPT |-> wb_dat_o[2:0] == 3'h2)
    else $error("link speed not 010b");
  a_mrec_soft_keep: assert property (soft_rst |=> $stable(mrec_reg))
    else $error("max request changed by software reset");
  // the stored word itself is checked, not the write strobe that feeds it
  a_swap_on_match: assert property (
    state_reg == CS_CMP && mem_rdata == cmp_reg
    |=> u_mem.mem_reg[sel_reg] == $past(data_reg))
    else $error("matching swap did not store the new data");
  a_ack_one_cycle: assert property (ack_reg |=> !ack_reg)
    else $error("ack held longer than one cycle");

endmodule : ohcib_regs

// [rtl/ohcib_res_mem.sv]
// four-word store of the bus-management resources
// assumes one writer; read data is registered, one cycle latency
`timescale 1ns/1ps
module ohcib_res_mem
  import ohcib_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        we_i,
  input  wire logic [1:0]  waddr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [1:0]  raddr_i,
  output logic      [31:0] rdata_o
);

  logic [31:0] mem_reg  [4];
  logic [31:0] mem_next [4];
  logic [31:0] rdata_next;

  // write port and registered read port
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      mem_next[i] = mem_reg[i];
    end
    if (we_i) begin
      mem_next[waddr_i] = wdata_i;
    end
    rdata_next = mem_reg[raddr_i];
  end

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) begin
      mem_reg[i] <= rst_i ? 32'h00000000 : mem_next[i];
    end
    rdata_o <= rst_i ? 32'h00000000 : rdata_next;
  end

endmodule : ohcib_res_mem
